/* File: logic/bso_aux_if.sv */
// Carrier between the sequencer core and its helpers.
// Assumes one producer per signal, all on clk_sys_in.
interface bso_aux_if;
    logic contact;   // Synchronised brake contact
    logic relay;     // Synchronised relay feedback
    logic tick;      // 10 ms step pulse
    modport syn  (output contact, output relay);
    modport tmr  (output tick);
    modport core (input contact, input relay, input tick);
endinterface

/* File: logic/bso_core.sv */
// Brake sequencer: release, run, engage, ramp and restart with option handling.
// Assumes Avalon-MM master on clk_sys_in; run and reversal come from same-clock logic.
`include "bso_map.svh"
module bso_core #(
    parameter int unsigned TICK_CYCLES = `BSO_TICK_CYCLES
) (
    input  wire logic        clk_sys_in,
    input  wire logic        nrst_in,
    input  wire logic [5:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        run_cmd_in,
    input  wire logic        reversal_in,
    input  wire logic        brake_contact_input_in,
    input  wire logic        relay_feedback_in,
    output logic             brake_release_out,
    output logic             ref_enable_out,
    output logic             current_ramp_out,
    output logic             zero_speed_hold_out,
    output logic             brake_feedback_error_out,
    output logic             brake_contact_warning_out,
    output logic             irq_out
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    bso_aux_if aux ();

    bso_sync u_sync (
        .clk_sys_in     (clk_sys_in),
        .nrst_in        (nrst_in),
        .contact_pin_in (brake_contact_input_in),
        .relay_pin_in   (relay_feedback_in),
        .aux            (aux.syn)
    );

    bso_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .aux        (aux.tmr)
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        bso_pkg::bso_state_t      st;        // Sequencer state
        bso_pkg::bso_time_t       cnt;       // Ticks in current state
        logic [`BSO_CTL_W-1:0]    ctrl;      // Option bits
        bso_pkg::bso_time_t       restart;   // Restart interval
        bso_pkg::bso_time_t       edly;      // Engage request delay
        bso_pkg::bso_time_t       etime;     // Engage duration
        bso_pkg::bso_time_t       rtime;     // Release duration
        bso_pkg::bso_time_t       ramp;      // Current ramp duration
        bso_pkg::bso_time_t       filt_a;    // Contact filter time
        bso_pkg::bso_time_t       filt_b;    // Relay filter time
        logic                     pend;      // Release after engage ends
        logic                     reinit;    // Reversal forces full sequence
        logic [`BSO_IRQ_W-1:0]    irq_stat;  // Sticky events
        logic [`BSO_IRQ_W-1:0]    irq_mask;  // Event mask
        logic [31:0]              rdata;     // Read data
        logic                     wait_r;    // Waitrequest
        logic                     brake;     // Brake release output
        logic                     refen;     // Reference enable
        logic                     rampo;     // Current ramp active
        logic                     hold;      // Zero-speed hold
        logic                     irq;       // Interrupt line
        logic                     ferr;      // Feedback error output
    } bso_core_st_t;
    bso_core_st_t s_q;
    bso_core_st_t s_d;

    // Larger of two step counts
    function automatic bso_pkg::bso_time_t tmax(input bso_pkg::bso_time_t a, input bso_pkg::bso_time_t b);
        tmax = (a > b) ? a : b;
    endfunction

    // Interval elapsed once count reaches target
    function automatic logic expired(input bso_pkg::bso_time_t c, input bso_pkg::bso_time_t t);
        expired = (c >= t);
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic                  take;      // Bus request accepted this edge
        logic                  fclr;      // Fault clear written
        logic [`BSO_IRQ_W-1:0] ev;        // Events this cycle
        logic                  sel1;      // Shortcut restart handling
        logic                  closed;    // Closed-loop control
        logic                  gate;      // Contact gating
        bso_pkg::bso_time_t    eng_eff;   // Effective engage time
        take    = 1'b0;
        fclr    = 1'b0;
        ev      = '0;
        sel1    = 1'b0;
        closed  = 1'b0;
        gate    = 1'b0;
        eng_eff = '0;
        s_d     = s_q;

        // Avalon slave: one wait cycle, then accept
        take = (avs_read_in | avs_write_in) & ~s_q.wait_r;
        s_d.wait_r = ~((avs_read_in | avs_write_in) & s_q.wait_r);
        if (avs_read_in && s_q.wait_r) begin
            case (avs_address_in[5:2])
                `BSO_ADR_CTRL:     s_d.rdata = 32'(s_q.ctrl);
                `BSO_ADR_RESTART:  s_d.rdata = 32'(s_q.restart);
                `BSO_ADR_EDLY:     s_d.rdata = 32'(s_q.edly);
                `BSO_ADR_ETIME:    s_d.rdata = 32'(s_q.etime);
                `BSO_ADR_RTIME:    s_d.rdata = 32'(s_q.rtime);
                `BSO_ADR_RAMP:     s_d.rdata = 32'(s_q.ramp);
                `BSO_ADR_FILT:     s_d.rdata = (32'(s_q.filt_b) << `BSO_FILT_B_LSB) | 32'(s_q.filt_a);
                `BSO_ADR_STATUS:   s_d.rdata = {14'h0000, aux.relay, aux.contact, 7'h00, s_q.st};
                `BSO_ADR_IRQ_STAT: s_d.rdata = 32'(s_q.irq_stat);
                `BSO_ADR_IRQ_MASK: s_d.rdata = 32'(s_q.irq_mask);
                default:           s_d.rdata = 32'h0000_0000;  // Unmapped reads zero
            endcase
        end
        if (take && avs_write_in) begin
            case (avs_address_in[5:2])
                `BSO_ADR_CTRL: begin
                    s_d.ctrl = avs_writedata_in[`BSO_CTL_W-1:0];
                    fclr = avs_writedata_in[`BSO_CTL_FAULT_CLR];
                end
                `BSO_ADR_RESTART:  s_d.restart  = avs_writedata_in[`BSO_TIME_W-1:0];
                `BSO_ADR_EDLY:     s_d.edly     = avs_writedata_in[`BSO_TIME_W-1:0];
                `BSO_ADR_ETIME:    s_d.etime    = avs_writedata_in[`BSO_TIME_W-1:0];
                `BSO_ADR_RTIME:    s_d.rtime    = avs_writedata_in[`BSO_TIME_W-1:0];
                `BSO_ADR_RAMP:     s_d.ramp     = avs_writedata_in[`BSO_TIME_W-1:0];
                `BSO_ADR_FILT: begin
                    s_d.filt_a = avs_writedata_in[`BSO_TIME_W-1:0];
                    s_d.filt_b = avs_writedata_in[`BSO_FILT_B_LSB +: `BSO_TIME_W];
                end
                `BSO_ADR_IRQ_MASK: s_d.irq_mask = avs_writedata_in[`BSO_IRQ_W-1:0];
                default: begin
                    // Writes elsewhere are ignored
                end
            endcase
        end

        // Option decode; same in open and closed loop, but missing_feedback_sel only acts in closed loop
        sel1    = s_q.ctrl[`BSO_CTL_RESTART_SEL] & ~s_q.reinit;
        closed  = s_q.ctrl[`BSO_CTL_CLOSED_LOOP];
        gate    = s_q.ctrl[`BSO_CTL_GATING_SEL];
        eng_eff = tmax(s_q.etime, tmax(s_q.filt_a, s_q.filt_b));

        // Step counter
        if (aux.tick && s_q.cnt != {`BSO_TIME_W{1'b1}}) begin
            s_d.cnt = s_q.cnt + 11'h001;
        end

        // Sequencer
        case (s_q.st)
            bso_pkg::BSO_IDLE: begin
                if (run_cmd_in) begin
                    s_d.st = bso_pkg::BSO_REL;
                end
            end
            bso_pkg::BSO_REL: begin
                if (gate) begin
                    if (aux.contact) begin
                        s_d.st = bso_pkg::BSO_RUN;
                    end
                end else if (expired(s_q.cnt, s_q.rtime)) begin
                    if (!aux.contact) begin
                        s_d.st = bso_pkg::BSO_FAULT;
                        ev[`BSO_IRQ_ERR] = 1'b1;
                    end else begin
                        s_d.st = bso_pkg::BSO_RUN;
                    end
                end
            end
            bso_pkg::BSO_RUN: begin
                s_d.pend = 1'b0;
                if (!s_q.ctrl[`BSO_CTL_STEADY_DIS] && !aux.contact) begin
                    s_d.st = bso_pkg::BSO_FAULT;
                    ev[`BSO_IRQ_ERR] = 1'b1;
                end else if (!run_cmd_in) begin
                    s_d.st     = bso_pkg::BSO_EDLY;
                    s_d.reinit = 1'b0;
                end else if (reversal_in && s_q.ctrl[`BSO_CTL_REVERSAL]) begin
                    s_d.st     = bso_pkg::BSO_EDLY;
                    s_d.reinit = 1'b1;
                    ev[`BSO_IRQ_REINIT] = 1'b1;
                end
            end
            bso_pkg::BSO_EDLY: begin
                if (run_cmd_in && sel1) begin
                    s_d.st = bso_pkg::BSO_RUN;
                end else if (expired(s_q.cnt, s_q.edly)) begin
                    s_d.st = bso_pkg::BSO_ENG;
                end
            end
            bso_pkg::BSO_ENG: begin
                if (run_cmd_in && sel1) begin
                    s_d.pend = 1'b1;
                end
                if (expired(s_q.cnt, eng_eff) && (!gate || !aux.contact)) begin
                    if (closed && (aux.contact || aux.relay)) begin
                        if (s_q.ctrl[`BSO_CTL_MISSING_SEL]) begin
                            s_d.st = bso_pkg::BSO_HOLD;
                            ev[`BSO_IRQ_WARN] = 1'b1;
                        end else begin
                            s_d.st = bso_pkg::BSO_FAULT;
                            ev[`BSO_IRQ_ERR] = 1'b1;
                        end
                    end else if (s_q.pend || (run_cmd_in && sel1)) begin
                        s_d.st   = bso_pkg::BSO_REL;
                        s_d.pend = 1'b0;
                    end else begin
                        s_d.st = bso_pkg::BSO_RAMP;
                    end
                end
            end
            bso_pkg::BSO_RAMP: begin
                // Run here does not cut the sequence short
                if (expired(s_q.cnt, s_q.ramp)) begin
                    s_d.st = bso_pkg::BSO_RESTART;
                end
            end
            bso_pkg::BSO_RESTART: begin
                if (run_cmd_in) begin
                    s_d.st = bso_pkg::BSO_IDLE;
                    ev[`BSO_IRQ_REINIT] = 1'b1;
                end else if (expired(s_q.cnt, s_q.restart)) begin
                    s_d.st = bso_pkg::BSO_IDLE;
                    ev[`BSO_IRQ_DONE] = 1'b1;
                end
            end
            bso_pkg::BSO_HOLD, bso_pkg::BSO_FAULT: begin
                if (fclr) begin
                    s_d.st = bso_pkg::BSO_IDLE;
                end
            end
            default: begin
                s_d.st = bso_pkg::BSO_IDLE;
            end
        endcase

        // Fresh count on every state change
        if (s_d.st != s_q.st) begin
            s_d.cnt = `BSO_CNT_ZERO;
        end

        // Outputs follow the next state
        s_d.brake = (s_d.st == bso_pkg::BSO_REL) || (s_d.st == bso_pkg::BSO_RUN)
                  || (s_d.st == bso_pkg::BSO_EDLY);
        s_d.refen = (s_d.st == bso_pkg::BSO_RUN);
        s_d.rampo = (s_d.st == bso_pkg::BSO_RAMP);
        s_d.hold  = (s_d.st == bso_pkg::BSO_HOLD);
        s_d.ferr  = (s_d.st == bso_pkg::BSO_FAULT);

        // Sticky events; only bits that were read clear, a new event wins
        if (take && avs_read_in && avs_address_in[5:2] == `BSO_ADR_IRQ_STAT) begin
            s_d.irq_stat = (s_q.irq_stat & ~s_q.rdata[`BSO_IRQ_W-1:0]) | ev;
        end else begin
            s_d.irq_stat = s_q.irq_stat | ev;
        end
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
    end

    // ----------------------------------------
    // Register
    // ----------------------------------------
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_q          <= '0;
            s_q.st       <= bso_pkg::BSO_IDLE;
            s_q.ctrl     <= `BSO_RST_CTRL;
            s_q.restart  <= `BSO_RST_RESTART;
            s_q.edly     <= `BSO_RST_EDLY;
            s_q.etime    <= `BSO_RST_ETIME;
            s_q.rtime    <= `BSO_RST_RTIME;
            s_q.ramp     <= `BSO_RST_RAMP;
            s_q.filt_a   <= `BSO_RST_FILT;
            s_q.filt_b   <= `BSO_RST_FILT;
            s_q.wait_r   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Ports straight from flops
    assign avs_readdata_out          = s_q.rdata;
    assign avs_waitrequest_out       = s_q.wait_r;
    assign brake_release_out         = s_q.brake;
    assign ref_enable_out            = s_q.refen;
    assign current_ramp_out          = s_q.rampo;
    assign zero_speed_hold_out       = s_q.hold;
    assign brake_feedback_error_out  = s_q.ferr;
    assign brake_contact_warning_out = s_q.hold;
    assign irq_out                   = s_q.irq;
endmodule // bso_core

/* File: logic/bso_map.svh */
// Address map, field positions, reset values and timing figures of the brake sequencer.
// Assumes inclusion by bare name from every file that needs these constants.
`ifndef BSO_MAP_SVH
`define BSO_MAP_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define BSO_CLK_HZ        25000000       // System clock rate in Hz
`define BSO_TICK_MS       10             // Sequencer step in ms
`define BSO_TICK_CYCLES   ((`BSO_CLK_HZ / 1000) * `BSO_TICK_MS)

// ----------------------------------------
// Register word indices (address bits 5:2)
// ----------------------------------------
`define BSO_ADR_CTRL      4'h0           // Option bits, fault clear
`define BSO_ADR_RESTART   4'h1           // Restart interval
`define BSO_ADR_EDLY      4'h2           // Engage request delay
`define BSO_ADR_ETIME     4'h3           // Engage duration
`define BSO_ADR_RTIME     4'h4           // Release duration
`define BSO_ADR_RAMP      4'h5           // Current ramp duration
`define BSO_ADR_FILT      4'h6           // Two feedback filter times
`define BSO_ADR_STATUS    4'h7           // Live state
`define BSO_ADR_IRQ_STAT  4'h8           // Sticky events, read clears
`define BSO_ADR_IRQ_MASK  4'h9           // Interrupt mask

// ----------------------------------------
// Control fields
// ----------------------------------------
`define BSO_CTL_RESTART_SEL   0          // restart_handling_sel
`define BSO_CTL_STEADY_DIS    1          // steady_contact_err_disable
`define BSO_CTL_GATING_SEL    2          // contact_gating_sel
`define BSO_CTL_MISSING_SEL   3          // missing_feedback_sel
`define BSO_CTL_REVERSAL      4          // engage_on_reversal
`define BSO_CTL_CLOSED_LOOP   5          // Closed-loop motor control
`define BSO_CTL_FAULT_CLR     8          // Write 1: leave fault or hold
`define BSO_CTL_W             6          // Stored control width
`define BSO_FILT_B_LSB        16         // Second filter time position

// ----------------------------------------
// Interrupt bits
// ----------------------------------------
`define BSO_IRQ_ERR       0              // Brake feedback error
`define BSO_IRQ_WARN      1              // Brake contact warning
`define BSO_IRQ_DONE      2              // Sequence completed
`define BSO_IRQ_REINIT    3              // Sequence reinitialised
`define BSO_IRQ_W         4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BSO_RST_CTRL      6'h00
`define BSO_RST_RESTART   11'h000        // 0.00 s
`define BSO_RST_EDLY      11'h000        // 0.00 s
`define BSO_RST_ETIME     11'h032        // 0.50 s
`define BSO_RST_RTIME     11'h000
`define BSO_RST_RAMP      11'h000
`define BSO_RST_FILT      11'h000
`define BSO_TIME_W        11
`define BSO_CNT_ZERO      11'h000

`endif

/* File: logic/bso_pkg.sv */
// Types shared by the brake sequencer modules.
// Assumes bso_map.svh is compiled with it.
`include "bso_map.svh"
package bso_pkg;
    // Time in 10 ms steps
    typedef logic [`BSO_TIME_W-1:0] bso_time_t;

    // Sequencer states, one-hot
    typedef enum logic [8:0] {
        BSO_IDLE    = 9'b0_0000_0001,  // Brake engaged, no run
        BSO_REL     = 9'b0_0000_0010,  // Releasing
        BSO_RUN     = 9'b0_0000_0100,  // Reference enabled
        BSO_EDLY    = 9'b0_0000_1000,  // Engage request delay
        BSO_ENG     = 9'b0_0001_0000,  // Engaging
        BSO_RAMP    = 9'b0_0010_0000,  // Current ramp to zero
        BSO_RESTART = 9'b0_0100_0000,  // Restart interval
        BSO_HOLD    = 9'b0_1000_0000,  // Zero-speed hold on warning
        BSO_FAULT   = 9'b1_0000_0000   // Locked brake feedback error
    } bso_state_t;
endpackage

/* File: logic/bso_sync.sv */
// Two-stage synchronisers for the brake feedback pins.
// Assumes asynchronous pins; only the second stage is read outside.
module bso_sync (
    input  wire logic clk_sys_in,
    input  wire logic nrst_in,
    input  wire logic contact_pin_in,
    input  wire logic relay_pin_in,
    bso_aux_if.syn    aux
);
    // Stage 0 holds the raw sample, stage 1 the usable one
    typedef struct packed {
        logic [1:0] c;
        logic [1:0] r;
    } bso_sync_st_t;
    bso_sync_st_t s_q;
    bso_sync_st_t s_d;

    // Shift pins in
    always_comb begin
        s_d = s_q;
        s_d.c = {s_q.c[0], contact_pin_in};
        s_d.r = {s_q.r[0], relay_pin_in};
    end

    // Register
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign aux.contact = s_q.c[1];
    assign aux.relay   = s_q.r[1];
endmodule // bso_sync

/* File: logic/bso_tick.sv */
// Divides the system clock down to the 10 ms sequencer step.
// Assumes the period is given in system clock cycles.
`include "bso_map.svh"
module bso_tick #(
    parameter int unsigned TICK_CYCLES = `BSO_TICK_CYCLES
) (
    input  wire logic clk_sys_in,
    input  wire logic nrst_in,
    bso_aux_if.tmr    aux
);
    typedef struct packed {
        logic [17:0] cnt;   // Cycle count within a step
        logic        tick;  // One-cycle step pulse
    } bso_tick_st_t;
    bso_tick_st_t s_q;
    bso_tick_st_t s_d;

    // Count cycles, pulse on wrap
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt >= 18'(TICK_CYCLES - 1)) begin
            s_d.cnt  = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 18'h0_0001;
        end
    end

    // Register
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign aux.tick = s_q.tick;
endmodule // bso_tick

/* File: tb/bso_brake_model.sv */
// Holding brake: contact and relay follow the release command.
// Assumes a same-clock command; the bench may pin the contact.
module bso_brake_model #(parameter int LAG = 6) (
    input  wire logic clk_sys_in, release_in, stuck_in, stuck_val_in,
    output wire logic contact_out, relay_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [LAG-1:0] sh_q = '0;  // Mechanical travel
    // Lag of the armature behind the coil
    always @(posedge clk_sys_in)
        sh_q <= {sh_q[LAG-2:0], release_in};
    assign relay_out   = sh_q[0];
    assign contact_out = stuck_in ? stuck_val_in : sh_q[LAG-1];
endmodule  // bso_brake_model

/* File: tb/bso_checker.sv */
// Port assertions for the brake sequencer.
// Assumes binding into bso_core; one clock, async low reset.
module bso_checker (
    input wire logic        clk_sys_in, nrst_in, avs_read_in, avs_write_in, avs_waitrequest_out,
    input wire logic [5:0]  avs_address_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic        brake_contact_input_in, brake_release_out, ref_enable_out, current_ramp_out,
    input wire logic        zero_speed_hold_out, brake_feedback_error_out, brake_contact_warning_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       wr_ok;  // Write taken
    logic [2:0] ctl_q;  // Shadow options
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    assign wr_ok = avs_write_in && !avs_waitrequest_out;
    // Shadow of option bits
    always_ff @(posedge clk_sys_in or negedge nrst_in)
        if (!nrst_in)
            ctl_q <= 3'h0;
        else if (wr_ok && avs_address_in[5:2] == 4'h0)
            ctl_q <= avs_writedata_in[2:0];
    property p_wait_answer; (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
    a_wait_answer: assert property (p_wait_answer) else $error("no bus answer");
    property p_wait_one; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
    property p_ref_release; ref_enable_out |-> brake_release_out; endproperty
    a_ref_release: assert property (p_ref_release) else $error("reference with brake held");
    property p_ramp_engaged; current_ramp_out |-> !brake_release_out && !ref_enable_out; endproperty
    a_ramp_engaged: assert property (p_ramp_engaged) else $error("ramp while released");
    property p_hold_warn; $rose(zero_speed_hold_out) |-> brake_contact_warning_out && !brake_release_out; endproperty
    a_hold_warn: assert property (p_hold_warn) else $error("hold without warning");
    property p_err_locked; $fell(brake_feedback_error_out) |-> $past(wr_ok) || $past(wr_ok, 2); endproperty
    a_err_locked: assert property (p_err_locked) else $error("error left unasked");
    property p_gate_contact; ctl_q[2] && $rose(ref_enable_out) |-> $past(brake_contact_input_in, 2); endproperty
    a_gate_contact: assert property (p_gate_contact) else $error("reference before contact");
    property p_steady; (!ctl_q[1] && ref_enable_out && !brake_contact_input_in) [*3] |-> ##[0:3] brake_feedback_error_out; endproperty
    a_steady: assert property (p_steady) else $error("open contact not flagged");
endmodule  // bso_checker

bind bso_core bso_checker u_chk (.clk_sys_in, .nrst_in, .avs_read_in, .avs_write_in, .avs_waitrequest_out,
    .avs_address_in, .avs_writedata_in, .brake_contact_input_in, .brake_release_out, .ref_enable_out,
    .current_ramp_out, .zero_speed_hold_out, .brake_feedback_error_out, .brake_contact_warning_out);

/* File: tb/test_brake_sequence_options.sv */
// Bench for the brake sequencer: register bus, sequences, faults.
// Assumes bso_core with a 4-cycle tick and the brake model on its pins.
module test_brake_sequence_options;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys_in = 1'h0, nrst_in = 1'h0, avs_read_in = 1'h0, avs_write_in = 1'h0;
    logic        run_cmd_in = 1'h0, stuck = 1'h0, sval = 1'h0, rev = 1'h0;  // Run, contact override, reversal
    logic [5:0]  avs_address_in = 6'h00;
    logic [31:0] avs_writedata_in = 32'h0000_0000, q;  // q: last read
    logic [37:0] tbl [5] = '{{6'h00, 32'h0000_0000}, {6'h04, 32'h0000_0000}, {6'h08, 32'h0000_0000},
                             {6'h0C, 32'h0000_0032}, {6'h3C, 32'h0000_0000}};
    wire logic [31:0] avs_readdata_out;
    wire logic avs_waitrequest_out, brake_contact_input_in, relay_feedback_in, brake_release_out, ref_enable_out;
    wire logic current_ramp_out, zero_speed_hold_out, brake_feedback_error_out, brake_contact_warning_out, irq_out;
    wire logic [6:0] obs = {irq_out, brake_contact_warning_out, brake_feedback_error_out, zero_speed_hold_out,
                            current_ramp_out, ref_enable_out, brake_release_out};
    int mismatches = 0, samples_checked = 0, cyc = 0;
    bso_brake_model u_brake (.clk_sys_in, .release_in(brake_release_out), .stuck_in(stuck),
        .stuck_val_in(sval), .contact_out(brake_contact_input_in), .relay_out(relay_feedback_in));
    bso_core #(.TICK_CYCLES(4)) dut (.clk_sys_in, .nrst_in, .avs_address_in, .avs_read_in, .avs_write_in,
        .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .run_cmd_in, .reversal_in(rev),
        .brake_contact_input_in, .relay_feedback_in, .brake_release_out, .ref_enable_out, .current_ramp_out,
        .zero_speed_hold_out, .brake_feedback_error_out, .brake_contact_warning_out, .irq_out);
    initial forever #20 clk_sys_in = ~clk_sys_in;
    // Hang guard
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 10000) begin
            mismatches++;
            end_sim;
        end
    end
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    // One bus transfer, held until waitrequest is sampled low
    task automatic acc(logic w, logic [5:0] a, logic [31:0] d);
        avs_address_in   <= a;
        avs_writedata_in <= d;
        avs_read_in      <= !w;
        avs_write_in     <= w;
        do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'h0);
        q = avs_readdata_out;
        avs_read_in  <= 1'h0;
        avs_write_in <= 1'h0;
        @(posedge clk_sys_in);
    endtask
    task automatic wait_obs(string n, int i, logic v, int lim);
        int k = 0;
        while (obs[i] !== v && k < lim) begin
            @(posedge clk_sys_in);
            k++;
        end
        chk(n, obs[i], v);
    endtask
    task automatic clear;
        acc(1'h1, 6'h00, 32'h0000_0100);
        stuck <= 1'h0;
        sval  <= 1'h0;
        wait_obs("error", 4, 1'h0, 10);
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys_in);
        nrst_in <= 1'h1;
        @(posedge clk_sys_in);
        foreach (tbl[i]) begin
            acc(1'h0, tbl[i][37:32], 32'h0000_0000);
            chk("reset value", q, tbl[i][31:0]);
        end
        acc(1'h1, 6'h10, 32'h0000_0005);
        acc(1'h1, 6'h04, 32'h0000_000A);
        acc(1'h1, 6'h24, 32'h0000_0008);
        run_cmd_in <= 1'h1;
        wait_obs("ref", 1, 1'h1, 2000);
        run_cmd_in <= 1'h0;
        wait_obs("ramp", 2, 1'h1, 2000);
        wait_obs("ramp", 2, 1'h0, 20);
        acc(1'h0, 6'h1C, 32'h0000_0000);
        chk("state", q[8:0], 9'h040);
        run_cmd_in <= 1'h1;
        wait_obs("irq", 6, 1'h1, 50);
        acc(1'h0, 6'h20, 32'h0000_0000);
        chk("reinit", q[3], 1'h1);
        wait_obs("irq", 6, 1'h0, 4);
        acc(1'h1, 6'h04, 32'h0000_0000);
        wait_obs("ref", 1, 1'h1, 2000);
        stuck <= 1'h1;
        wait_obs("error", 4, 1'h1, 20);
        run_cmd_in <= 1'h0;
        clear;
        acc(1'h1, 6'h00, 32'h0000_0004);
        run_cmd_in <= 1'h1;
        wait_obs("release", 0, 1'h1, 50);
        chk("ref", obs[1], 1'h0);
        wait_obs("ref", 1, 1'h1, 2000);
        run_cmd_in <= 1'h0;
        wait_obs("ramp", 2, 1'h1, 2000);
        for (int s = 0; s < 2; s++) begin
            acc(1'h1, 6'h00, 32'h0000_0020 | (s << 3));
            run_cmd_in <= 1'h1;
            wait_obs("ref", 1, 1'h1, 2000);
            stuck      <= 1'h1;
            sval       <= 1'h1;
            run_cmd_in <= 1'h0;
            wait_obs("hold or error", s ? 3 : 4, 1'h1, 2000);
            chk("warning", obs[5], s);
            clear;
        end
        acc(1'h1, 6'h00, 32'h0000_0001);
        acc(1'h1, 6'h08, 32'h0000_0014);
        run_cmd_in <= 1'h1;
        wait_obs("ref", 1, 1'h1, 2000);
        run_cmd_in <= 1'h0;
        wait_obs("ref", 1, 1'h0, 20);
        chk("release", obs[0], 1'h1);
        run_cmd_in <= 1'h1;
        wait_obs("ref", 1, 1'h1, 30);
        acc(1'h1, 6'h00, 32'h0000_0013);
        stuck <= 1'h1;
        repeat (10) @(posedge clk_sys_in);
        chk("steady", obs[4], 1'h0);
        rev <= 1'h1;
        wait_obs("irq", 6, 1'h1, 20);
        rev <= 1'h0;
        wait_obs("ramp", 2, 1'h1, 2000);
        wait_obs("error", 4, 1'h1, 2000);
        end_sim;
    end
endmodule  // test_brake_sequence_options
